/* can_core_model.sv */
// far-side model of the can core: event source and abort responder
`timescale 1ns/1ps
module can_core_model (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire can_status_pkg::tx_events_s bench_tx,
   input  wire can_status_pkg::rx_events_s bench_rx,
   input  wire logic [3:0]                 abort_delay,
   input  wire logic [2:0]                 mbx_pending,
   input  wire logic [2:1]                 mbx_abort_req,
   output can_status_pkg::tx_events_s      tx_ev,
   output can_status_pkg::rx_events_s      rx_ev
);
   logic [3:0] cnt_ff;
   logic [2:1] hit_ff;
   logic [2:1] ab_ff;
   logic       idle_ff;
   wire  logic [2:1] want = mbx_abort_req & mbx_pending[2:1];

   // one answer per request; waits for the request to drop before rearming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 4'h0;
         hit_ff <= 2'h0;
         ab_ff <= 2'h0;
         idle_ff <= 1'b1;
      end else begin
         ab_ff <= 2'h0;
         if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) ab_ff <= hit_ff;
         end else if (idle_ff && (|want)) begin
            hit_ff <= want;
            cnt_ff <= abort_delay;
            idle_ff <= 1'b0;
         end else if (!(|mbx_abort_req)) begin
            idle_ff <= 1'b1;
         end
      end
   end

   // removal reported only for mailboxes really pending an abort
   always_comb begin
      tx_ev = bench_tx;
      tx_ev.tx_aborted = bench_tx.tx_aborted | {ab_ff, 1'b0};
      rx_ev = bench_rx;
   end
endmodule // can_core_model

/* can_status_pkg.sv */
// shared constants and types for the can transmit and fifo 0 status block
package can_status_pkg;
   localparam int          APB_ADDR_W      = 12;
   localparam int          NUM_MBX         = 3;
   localparam int          FIFO_DEPTH      = 3;
   // register byte offsets
   localparam logic [11:0] TX_STATUS_OFF   = 12'h008;
   localparam logic [11:0] RX_FIFO0_OFF    = 12'h00C;
   // reset values as the register images show them
   localparam logic [31:0] TX_STATUS_RST   = 32'h1C00_0000;
   localparam logic [31:0] RX_FIFO0_RST    = 32'h0000_0000;
   // transmit status field positions
   localparam int          MBX1_TX_ERR_BIT = 11;
   localparam int          MBX1_ABORT_BIT  = 15;
   localparam int          MBX2_DONE_BIT   = 16;
   localparam int          MBX2_OK_BIT     = 17;
   localparam int          MBX2_ARB_BIT    = 18;
   localparam int          MBX2_ERR_BIT    = 19;
   localparam int          MBX2_ABORT_BIT  = 23;
   localparam int          EMPTY_IDX_LSB   = 24;
   localparam int          EMPTY_LSB       = 26;
   localparam int          LOWEST_LSB      = 29;
   // receive fifo 0 field positions
   localparam int          COUNT_LSB       = 0;
   localparam int          FULL_BIT        = 3;
   localparam int          OVERRUN_BIT     = 4;
   localparam int          RELEASE_BIT     = 5;
   localparam logic [1:0]  COUNT_MAX       = 2'h3;

   // per-mailbox event pulses from the can core, one bit per mailbox
   typedef struct packed {
      logic [2:0] tx_request;
      logic [2:0] tx_ok;
      logic [2:0] tx_fail;
      logic [2:0] arb_lost;
      logic [2:0] tx_aborted;
   } tx_events_s;

   // transmit priority rank per mailbox, higher rank means lower priority
   typedef logic [2:0][1:0] prio_rank_t;

   // receive side event pulses from the can core
   typedef struct packed {
      logic msg_stored;
   } rx_events_s;
endpackage

/* can_tx_mailbox_rx_fifo_status.sv */
// apb status registers for can transmit mailboxes and receive fifo 0
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - mailbox 1 error flag sets on failed transmit, held until software writes 1.
// - mailbox 1 abort bit set by software only while pending, cleared on removal.
// - mailbox 2 done flag sets on finish, clears on new request or write 1.
// - mailbox 2 ok flag sets on success, reads 0 after failure, write 1 clears.
// - mailbox 2 arbitration lost flag sets on loss, cleared only by write 1.
// - mailbox 2 error flag sets on failed transmit, write 1 clears.
// - mailbox 2 abort bit set only while pending, cleared after removal.
// - empty index names lowest priority when all empty, else next free mailbox.
// - each mailbox empty flag reads 1 when nothing awaits transmission.
// - lowest priority flag marks the waiting mailbox of lowest priority when two or more wait, else 0.
// - fifo 0 count rises per stored message, falls per release.
// - fifo 0 full flag sets when three messages are stored, write 1 clears.
// - fifo 0 overrun sets on a message arriving while three are stored.
// - release write 1 frees output mailbox; ignored while fifo is empty.
module can_tx_mailbox_rx_fifo_status (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [can_status_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire can_status_pkg::tx_events_s  tx_ev,
   input  wire can_status_pkg::prio_rank_t  tx_prio_rank,
   input  wire can_status_pkg::rx_events_s  rx_ev,
   output logic      [2:0]                  mbx_pending,
   output logic      [2:1]                  mbx_abort_req,
   output logic                             fifo0_release_pulse
);

   // one-hot of the lowest-priority mailbox among those in mask
   function automatic logic [2:0] lowest_of(input logic [2:0] mask,
                                            input can_status_pkg::prio_rank_t r);
      logic [2:0] sel;
      logic [1:0] best;
      logic       found;
      sel   = 3'h0;
      best  = 2'h0;
      found = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (mask[i] && (!found || r[i] > best)) begin
            sel      = 3'h0;
            sel[i]   = 1'b1;
            best     = r[i];
            found    = 1'b1;
         end
      end
      return sel;
   endfunction

   function automatic logic [1:0] index_of(input logic [2:0] onehot);
      logic [1:0] idx;
      idx = 2'h0;
      if (onehot[1]) begin
         idx = 2'h1;
      end
      if (onehot[2]) begin
         idx = 2'h2;
      end
      return idx;
   endfunction

   // apb slave state
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic        pready_ff;
   logic        nxt_pready;
   logic        pslverr_ff;
   logic        nxt_pslverr;

   // transmit state
   logic [2:0]  pending_ff;
   logic [2:0]  nxt_pending;
   logic [2:1]  abort_ff;
   logic [2:1]  nxt_abort;
   logic        mbx1_tx_error_ff;
   logic        nxt_mbx1_tx_error;
   logic        mbx2_req_done_ff;
   logic        nxt_mbx2_req_done;
   logic        mbx2_tx_ok_ff;
   logic        nxt_mbx2_tx_ok;
   logic        mbx2_arb_lost_ff;
   logic        nxt_mbx2_arb_lost;
   logic        mbx2_tx_error_ff;
   logic        nxt_mbx2_tx_error;

   // receive fifo 0 state
   logic [1:0]  fifo0_msg_count_ff;
   logic [1:0]  nxt_fifo0_msg_count;
   logic        fifo0_full_ff;
   logic        nxt_fifo0_full;
   logic        fifo0_overrun_ff;
   logic        nxt_fifo0_overrun;
   logic        release_ff;
   logic        nxt_release;

   // decode and images
   logic        setup_phase;
   logic        access_done;
   logic        hit_tx;
   logic        hit_rx;
   logic [31:0] tx_w1;
   logic [31:0] rx_w1;
   logic [31:0] tx_image;
   logic [31:0] rx_image;
   logic [2:0]  mbx_empty;
   logic [2:0]  mbx_lowest_prio;
   logic [1:0]  empty_mailbox_index;
   logic        release_ok;

   assign hit_tx      = (paddr == can_status_pkg::TX_STATUS_OFF);
   assign hit_rx      = (paddr == can_status_pkg::RX_FIFO0_OFF);
   assign setup_phase = psel && !penable && !pready_ff;
   assign access_done = psel && penable && pready_ff;
   assign tx_w1 = (access_done && pwrite && hit_tx) ? pwdata : 32'h0;
   assign rx_w1 = (access_done && pwrite && hit_rx) ? pwdata : 32'h0;

   // status images, computed from live state
   always_comb begin
      mbx_empty       = ~pending_ff;
      mbx_lowest_prio = 3'h0;
      if ($countones(pending_ff) > 1) begin
         mbx_lowest_prio = lowest_of(pending_ff, tx_prio_rank);
      end
      if (&mbx_empty) begin
         empty_mailbox_index = index_of(lowest_of(3'h7, tx_prio_rank));
      end else if (mbx_empty[0]) begin
         empty_mailbox_index = 2'h0;
      end else if (mbx_empty[1]) begin
         empty_mailbox_index = 2'h1;
      end else if (mbx_empty[2]) begin
         empty_mailbox_index = 2'h2;
      end else begin
         empty_mailbox_index = 2'h0;
      end
      // unlisted bits stay zero
      tx_image = 32'h0;
      tx_image[can_status_pkg::MBX1_TX_ERR_BIT] = mbx1_tx_error_ff;
      tx_image[can_status_pkg::MBX1_ABORT_BIT]  = abort_ff[1];
      tx_image[can_status_pkg::MBX2_DONE_BIT]   = mbx2_req_done_ff;
      tx_image[can_status_pkg::MBX2_OK_BIT]     = mbx2_tx_ok_ff;
      tx_image[can_status_pkg::MBX2_ARB_BIT]    = mbx2_arb_lost_ff;
      tx_image[can_status_pkg::MBX2_ERR_BIT]    = mbx2_tx_error_ff;
      tx_image[can_status_pkg::MBX2_ABORT_BIT]  = abort_ff[2];
      tx_image[can_status_pkg::EMPTY_IDX_LSB +: 2] = empty_mailbox_index;
      tx_image[can_status_pkg::EMPTY_LSB +: 3]     = mbx_empty;
      tx_image[can_status_pkg::LOWEST_LSB +: 3]    = mbx_lowest_prio;
      rx_image = 32'h0;
      rx_image[can_status_pkg::COUNT_LSB +: 2]   = fifo0_msg_count_ff;
      rx_image[can_status_pkg::FULL_BIT]         = fifo0_full_ff;
      rx_image[can_status_pkg::OVERRUN_BIT]      = fifo0_overrun_ff;
      rx_image[can_status_pkg::RELEASE_BIT]      = release_ff;
   end

   // apb: zero wait, answer rises the cycle after setup
   always_comb begin
      nxt_pready  = setup_phase;
      nxt_pslverr = setup_phase && !(hit_tx || hit_rx);
      nxt_prdata  = prdata_ff;
      if (setup_phase) begin
         nxt_prdata = hit_tx ? tx_image : (hit_rx ? rx_image : 32'h0);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // transmit flags: hardware set always beats a software clear
   always_comb begin
      nxt_pending = (pending_ff | tx_ev.tx_request)
                    & ~(tx_ev.tx_ok | tx_ev.tx_aborted);
      // abort only sticks while a message waits
      nxt_abort[1] = (abort_ff[1] || tx_w1[can_status_pkg::MBX1_ABORT_BIT])
                     && pending_ff[1] && nxt_pending[1];
      nxt_abort[2] = (abort_ff[2] || tx_w1[can_status_pkg::MBX2_ABORT_BIT])
                     && pending_ff[2] && nxt_pending[2];
      nxt_mbx1_tx_error = tx_ev.tx_fail[1] || (mbx1_tx_error_ff
                     && !tx_w1[can_status_pkg::MBX1_TX_ERR_BIT]);
      nxt_mbx2_req_done = mbx2_req_done_ff
                     && !tx_w1[can_status_pkg::MBX2_DONE_BIT];
      if (tx_ev.tx_request[2]) begin
         nxt_mbx2_req_done = 1'b0;
      end
      if (tx_ev.tx_ok[2] || tx_ev.tx_aborted[2]) begin
         nxt_mbx2_req_done = 1'b1;
      end
      nxt_mbx2_tx_ok = mbx2_tx_ok_ff && !tx_w1[can_status_pkg::MBX2_OK_BIT];
      if (tx_ev.tx_fail[2]) begin
         nxt_mbx2_tx_ok = 1'b0;
      end
      if (tx_ev.tx_ok[2]) begin
         nxt_mbx2_tx_ok = 1'b1;
      end
      nxt_mbx2_arb_lost = tx_ev.arb_lost[2] || (mbx2_arb_lost_ff
                     && !tx_w1[can_status_pkg::MBX2_ARB_BIT]);
      nxt_mbx2_tx_error = tx_ev.tx_fail[2] || (mbx2_tx_error_ff
                     && !tx_w1[can_status_pkg::MBX2_ERR_BIT]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_ff       <= 3'h0;
         abort_ff         <= 2'h0;
         mbx1_tx_error_ff <= 1'b0;
         mbx2_req_done_ff <= 1'b0;
         mbx2_tx_ok_ff    <= 1'b0;
         mbx2_arb_lost_ff <= 1'b0;
         mbx2_tx_error_ff <= 1'b0;
      end else begin
         pending_ff       <= nxt_pending;
         abort_ff         <= nxt_abort;
         mbx1_tx_error_ff <= nxt_mbx1_tx_error;
         mbx2_req_done_ff <= nxt_mbx2_req_done;
         mbx2_tx_ok_ff    <= nxt_mbx2_tx_ok;
         mbx2_arb_lost_ff <= nxt_mbx2_arb_lost;
         mbx2_tx_error_ff <= nxt_mbx2_tx_error;
      end
   end

   // receive fifo 0; release acts in one cycle so its bit reads back 0
   assign release_ok = rx_w1[can_status_pkg::RELEASE_BIT]
                       && (fifo0_msg_count_ff != 2'h0);
   always_comb begin
      nxt_release         = release_ok;
      nxt_fifo0_msg_count = fifo0_msg_count_ff;
      nxt_fifo0_overrun   = fifo0_overrun_ff
                            && !rx_w1[can_status_pkg::OVERRUN_BIT];
      if (rx_ev.msg_stored && !release_ok) begin
         if (fifo0_msg_count_ff == can_status_pkg::COUNT_MAX) begin
            nxt_fifo0_overrun = 1'b1;
         end else begin
            nxt_fifo0_msg_count = fifo0_msg_count_ff + 2'h1;
         end
      end else if (release_ok && !rx_ev.msg_stored) begin
         nxt_fifo0_msg_count = fifo0_msg_count_ff - 2'h1;
      end
      nxt_fifo0_full = fifo0_full_ff && !rx_w1[can_status_pkg::FULL_BIT]
                       && (nxt_fifo0_msg_count == can_status_pkg::COUNT_MAX);
      if ((nxt_fifo0_msg_count == can_status_pkg::COUNT_MAX)
          && (fifo0_msg_count_ff != can_status_pkg::COUNT_MAX)) begin
         nxt_fifo0_full = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo0_msg_count_ff <= 2'h0;
         fifo0_full_ff      <= 1'b0;
         fifo0_overrun_ff   <= 1'b0;
         release_ff         <= 1'b0;
      end else begin
         fifo0_msg_count_ff <= nxt_fifo0_msg_count;
         fifo0_full_ff      <= nxt_fifo0_full;
         fifo0_overrun_ff   <= nxt_fifo0_overrun;
         release_ff         <= nxt_release;
      end
   end

   assign prdata              = prdata_ff;
   assign pready              = pready_ff;
   assign pslverr             = pslverr_ff;
   assign mbx_pending         = pending_ff;
   assign mbx_abort_req       = abort_ff;
   assign fifo0_release_pulse = release_ff; // core pops the oldest

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_mbx1_err_hold: assert property (
      mbx1_tx_error_ff && !tx_w1[can_status_pkg::MBX1_TX_ERR_BIT]
      |=> mbx1_tx_error_ff)
      else $error("mbx1 error flag lost without clear");

   chk_mbx1_err_set: assert property (
      tx_ev.tx_fail[1] |=> mbx1_tx_error_ff [*2] or
      (mbx1_tx_error_ff ##1 $past(tx_w1[can_status_pkg::MBX1_TX_ERR_BIT])))
      else $error("mbx1 error flag not set on failure");

   chk_abort_idle: assert property (
      tx_w1[can_status_pkg::MBX1_ABORT_BIT] && !pending_ff[1]
      |=> !abort_ff[1])
      else $error("mbx1 abort took effect with nothing pending");

   chk_abort_removed: assert property (
      abort_ff[2] && tx_ev.tx_aborted[2] |=> !abort_ff[2] && !pending_ff[2])
      else $error("mbx2 abort not cleared after removal");

   chk_done_request: assert property (
      tx_ev.tx_request[2] && !tx_ev.tx_ok[2] && !tx_ev.tx_aborted[2]
      |=> !mbx2_req_done_ff && pending_ff[2])
      else $error("mbx2 done not cleared on new request");

   chk_ok_fail: assert property (
      tx_ev.tx_fail[2] && !tx_ev.tx_ok[2] |=> !mbx2_tx_ok_ff)
      else $error("mbx2 ok flag kept after failure");

   chk_arb_sticky: assert property (
      tx_ev.arb_lost[2] ##1 !tx_w1[can_status_pkg::MBX2_ARB_BIT]
      |=> mbx2_arb_lost_ff)
      else $error("mbx2 arbitration lost flag dropped");

   chk_err2_set: assert property (
      $rose(mbx2_tx_error_ff) |-> $past(tx_ev.tx_fail[2]))
      else $error("mbx2 error flag rose without failure");

   chk_lowest_single: assert property (
      $countones(pending_ff) < 2 |-> mbx_lowest_prio == 3'h0)
      else $error("lowest priority flag with under two waiting");

   chk_index_empty: assert property (
      !(&mbx_empty) && (|mbx_empty) |-> mbx_empty[empty_mailbox_index])
      else $error("empty index names a full mailbox");

   chk_count_step: assert property (
      rx_ev.msg_stored && !release_ok && fifo0_msg_count_ff != 2'h3
      |=> fifo0_msg_count_ff == $past(fifo0_msg_count_ff) + 2'h1)
      else $error("fifo0 count did not step up");

   chk_full_reach: assert property (
      fifo0_msg_count_ff == 2'h2 && rx_ev.msg_stored && !release_ok
      |=> fifo0_full_ff && fifo0_msg_count_ff == 2'h3)
      else $error("fifo0 full not set at three");

   chk_overrun_set: assert property (
      fifo0_msg_count_ff == 2'h3 && rx_ev.msg_stored && !release_ok
      |=> fifo0_overrun_ff && fifo0_msg_count_ff == 2'h3)
      else $error("fifo0 overrun missed");

   chk_release_empty: assert property (
      fifo0_msg_count_ff == 2'h0 |=> !release_ff)
      else $error("release issued on empty fifo0");

   chk_full_drop: assert property (
      fifo0_msg_count_ff != 2'h3 |-> !fifo0_full_ff)
      else $error("fifo0 full below three messages");

   chk_reserved_zero: assert property (
      pready_ff && !pslverr_ff |-> prdata_ff[14:12] == 3'h0
      && prdata_ff[22:20] == 3'h0 && (prdata_ff[10:6] == 5'h0))
      else $error("reserved bits read nonzero");

endmodule // can_tx_mailbox_rx_fifo_status

/* can_tx_mailbox_rx_fifo_status_bench.sv */
// self-checking bench for the can transmit and fifo 0 status registers
`timescale 1ns/1ps
module can_tx_mailbox_rx_fifo_status_bench;
   localparam logic [11:0] TX     = can_status_pkg::TX_STATUS_OFF;
   localparam logic [11:0] RX     = can_status_pkg::RX_FIFO0_OFF;
   localparam logic [31:0] NO_IDX = 32'hFCFF_FFFF;
   localparam logic [31:0] ALL    = 32'hFFFF_FFFF;
   localparam logic [14:0] REQ2   = 15'h4000;
   localparam logic [14:0] REQ1   = 15'h2000;
   localparam logic [14:0] OK2    = 15'h0800;
   localparam logic [14:0] FAIL2  = 15'h0100;
   localparam logic [14:0] FAIL1  = 15'h0080;
   localparam logic [14:0] ARB2   = 15'h0020;
   logic                       pclk, presetn, psel, penable, pwrite;
   logic                       pready, pslverr, fifo0_release_pulse, err;
   logic [11:0]                paddr;
   logic [31:0]                pwdata, prdata, q;
   logic [2:0]                 mbx_pending;
   logic [2:1]                 mbx_abort_req;
   logic [3:0]                 abort_delay;
   can_status_pkg::tx_events_s bench_tx, tx_ev;
   can_status_pkg::rx_events_s bench_rx, rx_ev;
   can_status_pkg::prio_rank_t tx_prio_rank;
   int                         n_mismatch = 0, comparisons = 0;
   int                         cycles = 0, n_release = 0;

   can_tx_mailbox_rx_fifo_status dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_ev(tx_ev), .tx_prio_rank(tx_prio_rank), .rx_ev(rx_ev),
      .mbx_pending(mbx_pending), .mbx_abort_req(mbx_abort_req),
      .fifo0_release_pulse(fifo0_release_pulse));
   can_core_model core (.pclk(pclk), .presetn(presetn), .bench_tx(bench_tx),
      .bench_rx(bench_rx), .abort_delay(abort_delay),
      .mbx_pending(mbx_pending), .mbx_abort_req(mbx_abort_req),
      .tx_ev(tx_ev), .rx_ev(rx_ev));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (fifo0_release_pulse === 1'b1) n_release++;
      cycles++;
      // the whole sequence needs well under a thousand cycles
      if (cycles == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g, m);
      comparisons++;
      if ((g & m) !== (e & m)) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", n, e & m, g & m);
      end
   endtask

   // request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rq,
                      output logic re);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no local wait limit: only the cycle ceiling ends a hang
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input string n, input logic [11:0] a,
                     input logic [31:0] e, m);
      apb(1'b0, a, 32'h0, q, err);
      chk(n, e, q, m);
      chk("pslverr", 32'h0, {31'h0, err}, ALL);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, err);
   endtask

   task automatic ev(input logic [14:0] t, input logic r);
      @(posedge pclk);
      bench_tx <= t;
      bench_rx <= r;
      @(posedge pclk);
      bench_tx <= '0;
      bench_rx <= 1'b0;
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      bench_tx = '0;
      bench_rx = '0;
      abort_delay = 4'h8;
      // mailbox 0 lowest priority, mailbox 2 highest
      tx_prio_rank = 6'h06;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd("tx reset", TX, 32'h1C00_0000, ALL);
      rd("rx reset", RX, 32'h0, ALL);
      apb(1'b0, 12'h010, 32'h0, q, err);
      chk("unmapped data", 32'h0, q, ALL);
      chk("unmapped err", 32'h1, {31'h0, err}, ALL);
      ev(REQ2, 1'b0);
      rd("one waiting", TX, 32'h0C00_0000, NO_IDX);
      chk("pending", 32'h4, {29'h0, mbx_pending}, ALL);
      ev(FAIL2, 1'b0);
      rd("mbx2 fail", TX, 32'h0C08_0000, NO_IDX);
      ev(ARB2, 1'b0);
      rd("mbx2 arb", TX, 32'h0C0C_0000, NO_IDX);
      wr(TX, 32'h0070_7000);
      rd("reserved", TX, 32'h0C0C_0000, NO_IDX);
      wr(TX, 32'h0008_0000);
      rd("err clear", TX, 32'h0C04_0000, NO_IDX);
      wr(TX, 32'h0004_0000);
      rd("arb clear", TX, 32'h0C00_0000, NO_IDX);
      ev(OK2, 1'b0);
      rd("mbx2 ok", TX, 32'h1C03_0000, ALL);
      ev(REQ2, 1'b0);
      rd("done drop", TX, 32'h0C02_0000, NO_IDX);
      ev(FAIL2, 1'b0);
      rd("ok drop", TX, 32'h0C08_0000, NO_IDX);
      ev(REQ1, 1'b0);
      rd("two waiting", TX, 32'h4408_0000, ALL);
      ev(FAIL1, 1'b0);
      rd("mbx1 fail", TX, 32'h4408_0800, ALL);
      wr(TX, 32'h0008_0800);
      rd("both clear", TX, 32'h4400_0000, ALL);
      // slow core: the abort bit must stand while removal is pending
      wr(TX, 32'h0000_8000);
      rd("abort1 held", TX, 32'h4400_8000, ALL);
      chk("abort out", 32'h1, {30'h0, mbx_abort_req}, ALL);
      repeat (12) @(posedge pclk);
      rd("abort1 done", TX, 32'h0C00_0000, NO_IDX);
      wr(TX, 32'h0000_8000);
      rd("abort1 idle", TX, 32'h0C00_0000, NO_IDX);
      chk("abort idle", 32'h0, {30'h0, mbx_abort_req}, ALL);
      abort_delay <= 4'h1;
      wr(TX, 32'h0080_0000);
      repeat (4) @(posedge pclk);
      rd("abort2 done", TX, 32'h1C01_0000, ALL);
      repeat (4) ev(15'h0, 1'b1);
      rd("fifo over", RX, 32'h0000_001B, ALL);
      wr(RX, 32'h0000_0020);
      rd("release", RX, 32'h0000_0012, ALL);
      wr(RX, 32'h0000_0010);
      rd("ovr clear", RX, 32'h0000_0002, ALL);
      // software pops oldest first; third release finds the fifo empty
      repeat (3) wr(RX, 32'h0000_0020);
      rd("empty", RX, 32'h0, ALL);
      chk("release pulses", 32'h3, n_release, ALL);
      repeat (3) ev(15'h0, 1'b1);
      wr(RX, 32'h0000_0008);
      rd("full clear", RX, 32'h0000_0003, ALL);
      complete_run();
   end
endmodule // can_tx_mailbox_rx_fifo_status_bench
